// ---- inc/two_wire_defs.vh ----
// Constants for the two-wire bus controller: map, fields, codes, timing
`ifndef TWO_WIRE_DEFS_VH
`define TWO_WIRE_DEFS_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define ADR_DIV  8'h00
`define ADR_CTL  8'h04
`define ADR_STAT 8'h08
`define ADR_DATA 8'h0C
`define ADR_OWN  8'h10

// ------------------------------------------------------------
// Control field positions and reset values
// ------------------------------------------------------------
`define BIT_DONE 7
`define BIT_AEN  6
`define BIT_STA  5
`define BIT_STO  4
`define BIT_WCOL 3
`define BIT_EN   2
`define BIT_IE   0
`define REG_RST  8'h00

// ------------------------------------------------------------
// Timing: half period is base plus divider times four to the power of prescale
// ------------------------------------------------------------
`define HALF_BASE 15'h0008
`define LAST_BIT  4'h7
`define ACK_BIT   4'h8

// ------------------------------------------------------------
// Status codes, prescaler bits zero
// ------------------------------------------------------------
`define STS_NONE        8'hF8
`define STS_BUS_ERR     8'h00
`define STS_START       8'h08
`define STS_RSTART      8'h10
`define STS_MTX_ADR_ACK 8'h18
`define STS_MTX_ADR_NAK 8'h20
`define STS_MTX_DAT_ACK 8'h28
`define STS_MTX_DAT_NAK 8'h30
`define STS_ARB_LOST    8'h38
`define STS_MRX_ADR_ACK 8'h40
`define STS_MRX_ADR_NAK 8'h48
`define STS_MRX_DAT_ACK 8'h50
`define STS_MRX_DAT_NAK 8'h58
`define STS_SRX_ADR     8'h60
`define STS_SRX_ARB     8'h68
`define STS_GEN_ADR     8'h70
`define STS_GEN_ARB     8'h78
`define STS_SRX_DAT_ACK 8'h80
`define STS_SRX_DAT_NAK 8'h88
`define STS_GEN_DAT_ACK 8'h90
`define STS_GEN_DAT_NAK 8'h98
`define STS_SLV_STOP    8'hA0
`define STS_STX_ADR     8'hA8
`define STS_STX_ARB     8'hB0
`define STS_STX_DAT_ACK 8'hB8
`define STS_STX_DAT_NAK 8'hC0
`define STS_STX_LAST    8'hC8

`endif

// ---- design/two_wire_master_slave_control.v ----
// Two-wire bus controller, master and slave, behind an APB slave
//
// Notes on behaviour
// - Flag clear: status reads F8
// - Misplaced START/STOP reports status 00
// - Bus error sets the job-done flag
// - Stop plus flag clear recovers, lines released
// - Status F8 needs no software action
// - Repeated start keeps bus ownership
// - Identical traffic from masters: no contention
// - Sending one while reading zero loses
// - Lost in data: idle or restart
// - Lost in address: check own address
// - Divider register sets serial clock rate
// - Job-done flag bit 7, gated interrupt
// - Flag set holds serial clock low; here only as master or addressed slave
// - Write one clears flag, starts next step
// - Acknowledge enable drives ACK on matches
// - Acknowledge enable clear disconnects slave
// - Inaccessible data write flags collision
// - Status code bits 7..3, prescaler 1..0
// - Collision set when flag low, cleared high
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.vh"

module two_wire_master_slave_control (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        pce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        gie,
  output reg         irq,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe
);

  localparam [2:0] FS_IDLE  = 3'h0;
  localparam [2:0] FS_START = 3'h1;
  localparam [2:0] FS_XFER  = 3'h2;
  localparam [2:0] FS_HOLD  = 3'h3;
  localparam [2:0] FS_STOP  = 3'h4;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg        scl_m, scl_s, scl_p;
  reg        sda_m, sda_s, sda_p;
  reg [7:0]  div_q, own_q, dat_q, stat_q, sh_q;
  reg [1:0]  pre_q, ph_q;
  reg        done_q, aen_q, sta_q, sto_q, wcol_q, en_q, ie_q;
  reg [2:0]  fsm_q;
  reg [14:0] tcnt_q;
  reg [3:0]  bit_q;
  reg        mst_q, tx_q, adr_q, rd_q, gc_q, lost_q, addd_q;
  reg        ackrx_q, acktx_q, berr_q, busy_q, cont_q, rs_q;
  reg [7:0]  rd_data, ctl_v, end_st;
  reg        map_ok;

  // Own address or enabled general call, only with acknowledge on
  function match;
    input [7:0] b;
    input [7:0] own;
    input       en;
    begin
      match = en & ((b[7:1] == own[7:1]) |
                    ((b[7:1] == 7'h00) & own[0]));
    end
  endfunction

  // ------------------------------------------------------------
  // Bus line events
  // ------------------------------------------------------------
  wire scl_rise  = scl_s & ~scl_p;
  wire scl_fall  = ~scl_s & scl_p;
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  // Half period of the generated clock
  wire [14:0] half_w = `HALF_BASE +
                       ({7'h00, div_q} << {pre_q, 1'b0});
  wire        tdone  = (tcnt_q >= half_w);
  wire [14:0] tnext  = tcnt_q + 15'h0001;

  // ------------------------------------------------------------
  // APB decode; a write lands at the completing edge only
  // ------------------------------------------------------------
  wire wr     = psel & penable & pready & pwrite;
  wire wr_div = wr & (paddr == `ADR_DIV);
  wire wr_ctl = wr & (paddr == `ADR_CTL);
  wire wr_st  = wr & (paddr == `ADR_STAT);
  wire wr_dat = wr & (paddr == `ADR_DATA);
  wire wr_own = wr & (paddr == `ADR_OWN);
  wire [7:0] stat_view = done_q ? stat_q : `STS_NONE;

  // Read mux; unmapped addresses read zero with an error
  always @* begin
    ctl_v = 8'h00;
    ctl_v[`BIT_DONE] = done_q;
    ctl_v[`BIT_AEN]  = aen_q;
    ctl_v[`BIT_STA]  = sta_q;
    ctl_v[`BIT_STO]  = sto_q;
    ctl_v[`BIT_WCOL] = wcol_q;
    ctl_v[`BIT_EN]   = en_q;
    ctl_v[`BIT_IE]   = ie_q;
    map_ok = 1'b1;
    case (paddr)
      `ADR_DIV:  rd_data = div_q;
      `ADR_CTL:  rd_data = ctl_v;
      `ADR_STAT: rd_data = {stat_view[7:3], 1'b0, pre_q};
      `ADR_DATA: rd_data = dat_q;
      `ADR_OWN:  rd_data = own_q;
      default: begin
        rd_data = 8'h00;
        map_ok  = 1'b0;
      end
    endcase
  end

  // Status at the end of a byte, from role and acknowledge
  always @* begin
    if (lost_q & ~addd_q)
      end_st = `STS_ARB_LOST;
    else if (mst_q & adr_q) begin
      if (rd_q)
        end_st = ackrx_q ? `STS_MRX_ADR_ACK : `STS_MRX_ADR_NAK;
      else
        end_st = ackrx_q ? `STS_MTX_ADR_ACK : `STS_MTX_ADR_NAK;
    end else if (mst_q) begin
      if (tx_q)
        end_st = ackrx_q ? `STS_MTX_DAT_ACK : `STS_MTX_DAT_NAK;
      else
        end_st = acktx_q ? `STS_MRX_DAT_ACK : `STS_MRX_DAT_NAK;
    end else if (adr_q) begin
      if (rd_q)
        end_st = lost_q ? `STS_STX_ARB : `STS_STX_ADR;
      else if (gc_q)
        end_st = lost_q ? `STS_GEN_ARB : `STS_GEN_ADR;
      else
        end_st = lost_q ? `STS_SRX_ARB : `STS_SRX_ADR;
    end else if (tx_q) begin
      if (!ackrx_q)
        end_st = `STS_STX_DAT_NAK;
      else
        end_st = aen_q ? `STS_STX_DAT_ACK : `STS_STX_LAST;
    end else if (gc_q)
      end_st = acktx_q ? `STS_GEN_DAT_ACK : `STS_GEN_DAT_NAK;
    else
      end_st = acktx_q ? `STS_SRX_DAT_ACK : `STS_SRX_DAT_NAK;
  end

  // ------------------------------------------------------------
  // Pin synchronisers; third stage is the edge reference
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else if (pce) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // ------------------------------------------------------------
  // Registers, bus engine and APB answer in one process so that
  // hardware and software updates of shared bits have one driver
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      div_q   <= `REG_RST;
      own_q   <= `REG_RST;
      dat_q   <= `REG_RST;
      stat_q  <= `STS_NONE;
      sh_q    <= `REG_RST;
      pre_q   <= 2'h0;
      ph_q    <= 2'h0;
      done_q  <= 1'b0;
      aen_q   <= 1'b0;
      sta_q   <= 1'b0;
      sto_q   <= 1'b0;
      wcol_q  <= 1'b0;
      en_q    <= 1'b0;
      ie_q    <= 1'b0;
      fsm_q   <= FS_IDLE;
      tcnt_q  <= 15'h0000;
      bit_q   <= 4'h0;
      mst_q   <= 1'b0;
      tx_q    <= 1'b0;
      adr_q   <= 1'b0;
      rd_q    <= 1'b0;
      gc_q    <= 1'b0;
      lost_q  <= 1'b0;
      addd_q  <= 1'b0;
      ackrx_q <= 1'b0;
      acktx_q <= 1'b0;
      berr_q  <= 1'b0;
      busy_q  <= 1'b0;
      cont_q  <= 1'b0;
      rs_q    <= 1'b0;
    end else if (pce) begin
      // One wait state: ready rises in the second access cycle
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~map_ok;
      if (psel & penable & ~pready)
        prdata <= {24'h000000, rd_data};
      irq     <= done_q & ie_q & gie;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      // Software writes
      if (wr_div)
        div_q <= pwdata[7:0];
      if (wr_own)
        own_q <= pwdata[7:0];
      if (wr_st)
        pre_q <= pwdata[1:0];
      if (wr_ctl) begin
        aen_q <= pwdata[`BIT_AEN];
        sta_q <= pwdata[`BIT_STA];
        sto_q <= pwdata[`BIT_STO];
        en_q  <= pwdata[`BIT_EN];
        ie_q  <= pwdata[`BIT_IE];
        if (pwdata[`BIT_DONE])
          done_q <= 1'b0;
      end
      // Data only writable while the flag is up
      if (wr_dat) begin
        if (done_q) begin
          dat_q  <= pwdata[7:0];
          wcol_q <= 1'b0;
        end else
          wcol_q <= 1'b1;
      end
      // Bus busy between any START and STOP seen
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;

      case (fsm_q)
        // Watch for an address, or claim a free bus
        FS_IDLE: begin
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
          mst_q  <= 1'b0;
          addd_q <= 1'b0;
          lost_q <= 1'b0;
          if (en_q & start_det) begin
            fsm_q <= FS_XFER;
            adr_q <= 1'b1;
            tx_q  <= 1'b0;
            bit_q <= 4'h0;
          end else if (en_q & sta_q & ~busy_q) begin
            fsm_q  <= FS_START;
            ph_q   <= 2'h0;
            tcnt_q <= 15'h0000;
            rs_q   <= 1'b0;
          end
        end

        // START or repeated START; phases 2 and 3 raise lines
        FS_START: begin
          case (ph_q)
            2'h0: begin
              if (start_det) begin
                fsm_q <= FS_XFER;
                adr_q <= 1'b1;
                tx_q  <= 1'b0;
                bit_q <= 4'h0;
              end else if (tdone) begin
                sda_oe <= 1'b1;
                ph_q   <= 2'h1;
                tcnt_q <= 15'h0000;
              end else
                tcnt_q <= tnext;
            end
            2'h1: begin
              if (tdone) begin
                scl_oe <= 1'b1;
                done_q <= 1'b1;
                stat_q <= rs_q ? `STS_RSTART : `STS_START;
                mst_q  <= 1'b1;
                adr_q  <= 1'b1;
                tx_q   <= 1'b1;
                cont_q <= 1'b0;
                fsm_q  <= FS_HOLD;
              end else
                tcnt_q <= tnext;
            end
            2'h2: begin
              sda_oe <= 1'b0;
              if (tdone) begin
                scl_oe <= 1'b0;
                ph_q   <= 2'h3;
                tcnt_q <= 15'h0000;
              end else
                tcnt_q <= tnext;
            end
            default: begin
              if (!scl_s)
                tcnt_q <= 15'h0000;
              else if (tdone) begin
                ph_q   <= 2'h0;
                tcnt_q <= 15'h0000;
              end else
                tcnt_q <= tnext;
            end
          endcase
        end

        // Bit transfer for every role
        FS_XFER: begin
          // Clock generation; waits while a slave stretches
          if (mst_q) begin
            if (scl_oe) begin
              if (tdone) begin
                scl_oe <= 1'b0;
                tcnt_q <= 15'h0000;
              end else
                tcnt_q <= tnext;
            end else if (!scl_s)
              tcnt_q <= 15'h0000;
            else if (tdone) begin
              scl_oe <= 1'b1;
              tcnt_q <= 15'h0000;
            end else
              tcnt_q <= tnext;
          end
          if ((start_det | stop_det) & (bit_q != 4'h0)) begin
            berr_q <= 1'b1;
            done_q <= 1'b1;
            stat_q <= `STS_BUS_ERR;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            mst_q  <= 1'b0;
            fsm_q  <= FS_HOLD;
          end else if (stop_det) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            if (addd_q & ~mst_q) begin
              done_q <= 1'b1;
              stat_q <= `STS_SLV_STOP;
              cont_q <= 1'b0;
              addd_q <= 1'b0;
              fsm_q  <= FS_HOLD;
            end else
              fsm_q <= FS_IDLE;
          end else if (start_det & ~mst_q) begin
            adr_q  <= 1'b1;
            tx_q   <= 1'b0;
            addd_q <= 1'b0;
            lost_q <= 1'b0;
            sda_oe <= 1'b0;
          end else if (scl_rise) begin
            if (bit_q != `ACK_BIT) begin
              sh_q <= {sh_q[6:0], sda_s};
              // Only a driven one read back as zero loses
              if (mst_q & tx_q & sh_q[7] & ~sda_s) begin
                lost_q <= 1'b1;
                mst_q  <= 1'b0;
                tx_q   <= 1'b0;
                scl_oe <= 1'b0;
              end
            end else if (tx_q)
              ackrx_q <= ~sda_s;
          end else if (scl_fall) begin
            if (bit_q == `LAST_BIT) begin
              bit_q <= `ACK_BIT;
              if (adr_q & ~mst_q) begin
                if (match(sh_q, own_q, aen_q)) begin
                  sda_oe  <= 1'b1;
                  addd_q  <= 1'b1;
                  acktx_q <= 1'b1;
                  gc_q    <= (sh_q[7:1] == 7'h00);
                  rd_q    <= sh_q[0];
                end else begin
                  sda_oe <= 1'b0;
                  if (!lost_q)
                    fsm_q <= FS_IDLE;
                end
              end else if (adr_q) begin
                sda_oe <= 1'b0;
                rd_q   <= sh_q[0];
              end else if (~tx_q & ~lost_q) begin
                sda_oe  <= aen_q;
                acktx_q <= aen_q;
              end else
                sda_oe <= 1'b0;
            end else if (bit_q == `ACK_BIT) begin
              // Byte done: report; hold the clock if master or addressed
              done_q <= 1'b1;
              stat_q <= end_st;
              dat_q  <= sh_q;
              sda_oe <= 1'b0;
              bit_q  <= 4'h0;
              adr_q  <= 1'b0;
              fsm_q  <= FS_HOLD;
              scl_oe <= mst_q | addd_q;
              if (adr_q)
                tx_q <= mst_q ? ~rd_q : rd_q;
              cont_q <= addd_q & (tx_q ? (ackrx_q & aen_q) : acktx_q);
            end else begin
              bit_q  <= bit_q + 4'h1;
              sda_oe <= tx_q & ~sh_q[7];
            end
          end
        end
        // Flag up: wait for software, clock held if owned
        FS_HOLD: begin
          if (!done_q) begin
            tcnt_q <= 15'h0000;
            if (berr_q) begin
              berr_q <= 1'b0;
              sto_q  <= 1'b0;
              addd_q <= 1'b0;
              fsm_q  <= FS_IDLE;
            end else if (mst_q & sto_q) begin
              fsm_q <= FS_STOP;
              ph_q  <= 2'h0;
            end else if (mst_q & sta_q) begin
              fsm_q <= FS_START;
              ph_q  <= 2'h2;
              rs_q  <= 1'b1;
            end else if (mst_q | cont_q) begin
              fsm_q  <= FS_XFER;
              sh_q   <= dat_q;
              bit_q  <= 4'h0;
              sda_oe <= tx_q & ~dat_q[7];
              scl_oe <= mst_q;
            end else begin
              sto_q  <= 1'b0;
              scl_oe <= 1'b0;
              fsm_q  <= FS_IDLE;
            end
          end
        end
        // STOP: data low, clock up, then data up
        FS_STOP: begin
          if (ph_q == 2'h0) begin
            sda_oe <= 1'b1;
            if (tdone) begin
              scl_oe <= 1'b0;
              ph_q   <= 2'h1;
              tcnt_q <= 15'h0000;
            end else
              tcnt_q <= tnext;
          end else if (!scl_s)
            tcnt_q <= 15'h0000;
          else if (tdone) begin
            sda_oe <= 1'b0;
            sto_q  <= 1'b0;
            mst_q  <= 1'b0;
            fsm_q  <= FS_IDLE;
          end else
            tcnt_q <= tnext;
        end

        default: fsm_q <= FS_IDLE;
      endcase

      // Disable ends any traffic at once
      if (!en_q) begin
        fsm_q  <= FS_IDLE;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        mst_q  <= 1'b0;
      end
    end
  end

endmodule // two_wire_master_slave_control

`default_nettype wire

// ---- bench/two_wire_chk.sv ----
// Checker: bus handshake, interrupt gating and clock hold
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.vh"
module two_wire_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        gie,
  input wire logic        irq,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out
);
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Any write may clear the flag, so it excuses a clock release
  wire bad = paddr > `ADR_OWN || paddr[1:0] != 2'h0;
  wire wr_any = psel && pwrite;
  a_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_bad_addr: assert property (pready && bad |-> pslverr)
    else $error("unmapped access without error");
  a_good_addr: assert property (pready && !bad |-> !pslverr)
    else $error("mapped access flagged");
  a_status_fmt: assert property (pready && !pwrite && paddr == `ADR_STAT
    |-> prdata[31:8] == 24'h0 && !prdata[2]) else $error("status format");
  a_irq_gate: assert property (irq |-> $past(gie))
    else $error("interrupt while globally masked");
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
  a_scl_hold: assert property (irq && scl_oe && !wr_any
    && !$past(wr_any) |=> scl_oe) else $error("clock released early");
endmodule // two_wire_chk
`default_nettype wire

// ---- bench/two_wire_partner.sv ----
// Behavioural slave on the far side of the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module two_wire_partner #(parameter logic [6:0] ADR = 7'h2A) (
  input  wire logic       pclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic [7:0] hold,
  output logic            scl_oe,
  output logic            sda_oe
);
  logic       s_q = 1'h1, d_q = 1'h1, act = 1'h0, sel = 1'h0;
  logic       rd = 1'h0, adr = 1'h0, drv = 1'h0, e_scl = 1'h0, e_sda = 1'h0;
  logic [3:0] n = 4'h0;
  logic [7:0] sh = 8'h00, rx_byte = 8'h00, st = 8'h00;
  // Stretch counter lets the bench make this slave slow
  assign scl_oe = st != 8'h00 || e_scl;
  assign sda_oe = drv || e_sda;
  // Frame tracking on wire edges seen at the clock
  always @(posedge pclk) begin
    s_q <= scl;
    d_q <= sda;
    st <= (s_q && !scl) ? hold : (st != 8'h00 ? st - 8'h01 : 8'h00);
    if (s_q && scl && d_q && !sda) begin
      act <= 1'h1;
      adr <= 1'h1;
      n <= 4'h0;
      drv <= 1'h0;
    end else if (s_q && scl && !d_q && sda) begin
      act <= 1'h0;
      sel <= 1'h0;
      drv <= 1'h0;
    end else if (act && !s_q && scl) begin
      if (n == 4'h8) begin
        n <= 4'h0;
        adr <= 1'h0;
        if (adr) begin
          sel <= sh[7:1] == ADR;
          rd <= sh[0];
        end else if (sel && !rd) rx_byte <= sh;
        else if (sda) sel <= 1'h0; // Not acknowledged: read over
      end else begin
        sh <= {sh[6:0], sda};
        n <= n + 4'h1;
      end
    end else if (act && s_q && !scl) begin
      if (n == 4'h8) drv <= adr ? sh[7:1] == ADR : sel && !rd;
      else drv <= sel && rd && !adr && !tx_byte[3'h7 - n[2:0]];
    end
  end
  // START, three bits, then STOP in mid-byte
  task automatic bad_frame;
    begin
      e_sda <= 1'h1;
      repeat (40) @(posedge pclk);
      repeat (3) begin
        e_scl <= 1'h1;
        repeat (40) @(posedge pclk);
        e_scl <= 1'h0;
        repeat (40) @(posedge pclk);
      end
      e_sda <= 1'h0;
    end
  endtask
endmodule // two_wire_partner
`default_nettype wire

// ---- bench/tb_top.sv ----
// Testbench top for the two-wire controller
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_defs.vh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_total++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end
module tb_top;
  localparam logic [6:0] SLV = 7'h2A;
  localparam logic [7:0] TXB = 8'h3C;
  localparam logic [7:0] DONE = 8'h01 << `BIT_DONE;
  localparam logic [7:0] AEN = 8'h01 << `BIT_AEN;
  localparam logic [7:0] STA = 8'h01 << `BIT_STA;
  localparam logic [7:0] STO = 8'h01 << `BIT_STO;
  localparam logic [7:0] ENI = (8'h01 << `BIT_EN) | (8'h01 << `BIT_IE);
  localparam int HALF = `HALF_BASE + 3 * 4 + 1; // Count ends inclusive
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, gie = 1'h0, rerr;
  logic [7:0]  paddr = 8'h00, hold = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, irq, scl_out, scl_oe, sda_out, sda_oe;
  wire logic   p_scl, p_sda;
  wire logic   scl = !(scl_oe || p_scl);
  wire logic   sda = !(sda_oe || p_sda);
  int          err_total = 0, compares = 0;
  two_wire_master_slave_control two_wire_master_slave_control_inst (
    .pclk(pclk), .presetn(presetn), .pce(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gie(gie),
    .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  two_wire_partner #(.ADR(SLV)) two_wire_partner_inst (.pclk(pclk),
    .scl(scl), .sda(sda), .tx_byte(TXB), .hold(hold), .scl_oe(p_scl),
    .sda_oe(p_sda));
  // 50 MHz clock and a watchdog on the whole run
  initial forever #10 pclk = ~pclk;
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    conclude;
  end
  // ------------------------------------------------
  // Bus tasks
  // ------------------------------------------------
  task automatic conclude;
    begin
      $display("Counts: %0d compares, %0d mismatches", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Starts one edge late so psel never changes twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (pready !== 1'h1 && n < 16);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 16) begin
        err_total++;
        conclude;
      end
    end
  endtask
  task automatic wait_bit(input int b, input logic v);
    int k;
    begin
      k = 0;
      do begin
        apb(1'h0, `ADR_CTL, 8'h00);
        k++;
      end while (rdat[b] !== v && k < 400);
      if (k >= 400) begin
        err_total++;
        conclude;
      end
    end
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] code);
    begin
      apb(1'h1, `ADR_CTL, c);
      wait_bit(`BIT_DONE, 1'h1);
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("status", code, rdat[7:0] & 8'hF8)
    end
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_regs;
    begin
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("control reset", 32'h0, rdat)
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("status reset", 32'hF8, rdat)
      apb(1'h0, 8'h14, 8'h00);
      `CHK("unmapped", 1'h1, rerr)
      apb(1'h1, `ADR_STAT, 8'h01);
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("prescaler", 32'hF9, rdat)
      apb(1'h1, `ADR_DATA, 8'h55);
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("collision", 1'h1, rdat[`BIT_WCOL])
      apb(1'h1, `ADR_DIV, 8'h03);
      apb(1'h0, `ADR_DIV, 8'h00);
      `CHK("divider", 32'h3, rdat)
      $display("Test registers done");
    end
  endtask
  task automatic t_master;
    int c;
    begin
      gie <= 1'h1;
      step(ENI | STA, `STS_START);
      @(negedge pclk);
      `CHK("irq", 1'h1, irq)
      `CHK("scl held", 1'h0, scl)
      @(posedge pclk);
      gie <= 1'h0;
      repeat (3) @(negedge pclk);
      `CHK("irq masked", 1'h0, irq)
      apb(1'h1, `ADR_CTL, ENI);
      gie <= 1'h1;
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("flag kept", 1'h1, rdat[`BIT_DONE])
      apb(1'h1, `ADR_DATA, {SLV, 1'h0});
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("collision off", 1'h0, rdat[`BIT_WCOL])
      apb(1'h1, `ADR_CTL, DONE | ENI);
      c = 0;
      while (scl_oe !== 1'h0 && c < 400) begin
        @(negedge pclk);
        c++;
      end
      while (scl_oe !== 1'h1 && c < 400) begin
        @(negedge pclk);
        c++;
      end
      c = 0;
      while (scl_oe === 1'h1 && c < 400) begin
        @(negedge pclk);
        c++;
      end
      `CHK("low half", HALF, c)
      wait_bit(`BIT_DONE, 1'h1);
      apb(1'h1, `ADR_DATA, 8'hA5);
      step(DONE | ENI, `STS_MTX_DAT_ACK);
      `CHK("slave byte", 8'hA5, two_wire_partner_inst.rx_byte)
      step(DONE | STA | ENI, `STS_RSTART);
      @(negedge pclk);
      `CHK("bus kept", 1'h0, scl)
      apb(1'h1, `ADR_DATA, {SLV, 1'h1});
      step(DONE | ENI, `STS_MRX_ADR_ACK);
      hold <= 8'h1E;
      step(DONE | AEN | ENI, `STS_MRX_DAT_ACK);
      apb(1'h0, `ADR_DATA, 8'h00);
      `CHK("read byte", TXB, rdat[7:0])
      hold <= 8'h00;
      step(DONE | ENI, `STS_MRX_DAT_NAK);
      apb(1'h1, `ADR_CTL, DONE | STO | ENI);
      wait_bit(`BIT_STO, 1'h0);
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("idle status", 8'hF8, rdat[7:0] & 8'hF8)
      @(negedge pclk);
      `CHK("bus free", 2'h3, {scl, sda})
      $display("Test master done");
    end
  endtask
  task automatic t_buserr;
    begin
      apb(1'h1, `ADR_OWN, 8'h20);
      apb(1'h1, `ADR_CTL, AEN | ENI);
      two_wire_partner_inst.bad_frame;
      repeat (8) @(posedge pclk);
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("error flag", 1'h1, rdat[`BIT_DONE])
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("bus error", 8'h00, rdat[7:0] & 8'hF8)
      apb(1'h1, `ADR_CTL, DONE | STO | AEN | ENI);
      apb(1'h0, `ADR_CTL, 8'h00);
      `CHK("recovered", AEN | ENI, rdat[7:0])
      apb(1'h0, `ADR_STAT, 8'h00);
      `CHK("idle again", 8'hF8, rdat[7:0] & 8'hF8)
      @(negedge pclk);
      `CHK("released", 2'h0, {scl_oe, sda_oe})
      $display("Test bus error done");
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_master;
    t_buserr;
    conclude;
  end
endmodule // tb_top
bind two_wire_master_slave_control two_wire_chk two_wire_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .gie(gie), .irq(irq), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_out(sda_out));
`default_nettype wire
